// ==== verilog/shs_homing_sync.sv ====
// How it works
// - Encoder homing frame: 160 samples of value one, 0x0008 left justified.
// - Any homing frame puts the coder core into its home state.
// - Second consecutive encoder homing frame yields the decoder homing frame.
// - After a good full decoder homing frame, a partial match in the next frame resets too.
// - Input is an unmarked serial stream of 13-bit words (8-bit in companded mode) at 104 kbit/s.
// - Linear samples travel as 16-bit words, left justified, low 3 bits zero.
// - Each coded frame is 76 words, right justified in 16 bits.
// - Companded mode carries 8-bit samples; no bit alignment search needed.
// - Companded frames hold 160 one-byte samples; coded words stay 16-bit.
// - Decoder output samples are 13 bits left justified in 16 bits.
`timescale 1ns/1ps
`include "shs_regs.svh"
module shs_homing_sync #(
    parameter int              FIFO_DEPTH = 32,
    parameter logic [7:0]      HOME_BYTE  = 8'hd5,
    parameter shs_pkg::shs_word_t DHF_WORDS [76] = '{default: 16'h0000}
) (
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic                ser_clk_pin,
    input  wire logic                ser_data_pin,
    input  wire logic                comp_mode_pin,
    output shs_pkg::shs_word_t       enc_core_sample,
    output logic                     enc_core_sample_valid,
    output logic                     enc_core_home,
    input  wire shs_pkg::shs_word_t  enc_core_word,
    input  wire logic                enc_core_word_valid,
    output logic                     enc_core_word_ready,
    output shs_pkg::shs_word_t       coded_word,
    output logic                     coded_valid,
    input  wire logic                coded_ready,
    input  wire shs_pkg::shs_word_t  dec_in_word,
    input  wire logic                dec_in_valid,
    input  wire logic                dec_in_bad_frame,
    output logic                     dec_core_home,
    input  wire shs_pkg::shs_sample_t dec_core_sample,
    input  wire logic                dec_core_sample_valid,
    output shs_pkg::shs_word_t       dec_out_sample,
    output logic                     dec_out_valid
);
    import shs_pkg::*;

    // Pin synchronisers, two stages; serial clock gets three so edge detect skips the first
    logic [2:0] sclk_sync_q;
    logic [1:0] sdat_sync_q;
    logic [1:0] mode_sync_q;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sclk_sync_q <= '0;
            sdat_sync_q <= '0;
            mode_sync_q <= '0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], ser_clk_pin};
            sdat_sync_q <= {sdat_sync_q[0], ser_data_pin};
            mode_sync_q <= {mode_sync_q[0], comp_mode_pin};
        end
    end

    // Bit strobe and word length select
    wire       bit_stb   = sclk_sync_q[1] && !sclk_sync_q[2];
    wire       sdat      = sdat_sync_q[1];
    wire       comp_mode = mode_sync_q[1];
    wire [3:0] word_bits = comp_mode ? `SHS_COMP_BITS : `SHS_LIN_BITS;

    // deserialiser counts its own word boundaries
    logic [3:0]  bit_cnt_q;
    logic [11:0] shift_q;
    wire         word_done = bit_stb && (bit_cnt_q == word_bits - 4'd1);
    wire [12:0]  new_word  = {shift_q, sdat};
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bit_cnt_q <= '0;
            shift_q   <= '0;
        end else if (bit_stb) begin
            shift_q   <= new_word[11:0];
            bit_cnt_q <= word_done ? 4'd0 : bit_cnt_q + 4'd1;
        end
    end

    // homing sample test, linear or companded byte
    wire is_home_smp = comp_mode ? (new_word[7:0] == HOME_BYTE)
                                 : (new_word == `SHS_HOME_SAMPLE);

    // left justify linear; one byte per companded sample
    wire shs_word_t smp_word = comp_mode ? {`SHS_BYTE_PAD, new_word[7:0]}
                                         : {new_word, `SHS_LSB_PAD};

    // Sample counter and homing accumulation per frame
    shs_smp_cnt_t smp_cnt_q;
    logic         home_acc_q;
    logic         prev_home_q;
    wire          frame_end  = word_done && (smp_cnt_q == `SHS_LAST_SAMPLE);
    wire          frame_home = home_acc_q && is_home_smp;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            smp_cnt_q   <= '0;
            home_acc_q  <= 1'b1;
            prev_home_q <= 1'b0;
        end else if (word_done) begin
            smp_cnt_q  <= frame_end ? '0 : smp_cnt_q + 8'd1;
            home_acc_q <= frame_end ? 1'b1 : frame_home;
            if (frame_end) prev_home_q <= frame_home;
        end
    end

    // Sample to coder core, registered
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            enc_core_sample       <= '0;
            enc_core_sample_valid <= 1'b0;
            enc_core_home         <= 1'b0;
        end else begin
            enc_core_sample_valid <= word_done;
            if (word_done) enc_core_sample <= smp_word;
            enc_core_home <= frame_end && frame_home;
        end
    end

    // Coded word path; substitution runs until the end of the current 76-word coded frame
    shs_cw_cnt_t cw_cnt_q;
    logic        enc_sub_q;
    logic        fifo_in_ready;
    wire         cw_take = enc_core_word_valid && fifo_in_ready;
    wire         cw_last = cw_take && (cw_cnt_q == `SHS_LAST_WORD);
    // second homing frame in a row swaps in the homing pattern
    wire         sub_set = frame_end && frame_home && prev_home_q;
    // core words are already right justified; passed unchanged
    wire shs_word_t fifo_in_word = enc_sub_q ? DHF_WORDS[cw_cnt_q]
                                             : enc_core_word;
    assign enc_core_word_ready = fifo_in_ready;

    // Set wins over the end-of-frame clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cw_cnt_q  <= '0;
            enc_sub_q <= 1'b0;
        end else begin
            if (cw_take) cw_cnt_q <= cw_last ? '0 : cw_cnt_q + 7'd1;
            if (sub_set) enc_sub_q <= 1'b1;
            else if (cw_last) enc_sub_q <= 1'b0;
        end
    end

    // Output buffer; back-pressure stalls the coder core
    shs_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .in_valid  (enc_core_word_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_word),
        .out_valid (coded_valid),
        .out_ready (coded_ready),
        .out_data  (coded_word)
    );

    // Decoder homing detection over the 76 input words
    shs_cw_cnt_t dw_cnt_q;
    logic        full_acc_q;
    logic        part_acc_q;
    logic        armed_q;
    wire         dw_match  = (dec_in_word == DHF_WORDS[dw_cnt_q]);
    wire         dw_end    = dec_in_valid && (dw_cnt_q == `SHS_LAST_WORD);
    wire         full_hit  = full_acc_q && dw_match;
    wire         part_hit  = (dw_cnt_q > `SHS_PART_LAST_WORD) ? part_acc_q
                                                              : part_acc_q
                                                                && dw_match;
    // partial frame suffices once armed by a good full one
    wire         dec_home  = dw_end && (full_hit || (armed_q && part_hit));
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dw_cnt_q   <= '0;
            full_acc_q <= 1'b1;
            part_acc_q <= 1'b1;
            armed_q    <= 1'b0;
        end else if (dec_in_valid) begin
            dw_cnt_q   <= dw_end ? '0 : dw_cnt_q + 7'd1;
            full_acc_q <= dw_end ? 1'b1 : full_hit;
            part_acc_q <= dw_end ? 1'b1 : part_hit;
            if (dw_end) armed_q <= full_hit && !dec_in_bad_frame;
        end
    end

    // Decoder output mode for the next 160 samples
    shs_dec_mode_t dmode_q;
    shs_smp_cnt_t  ds_cnt_q;
    wire           ds_last = dec_core_sample_valid &&
                             (ds_cnt_q == `SHS_LAST_SAMPLE);
    // left justified 13-bit sample; homing output is 0x0008
    wire shs_word_t dec_word = (dmode_q == SHS_DEC_HOME_OUT) ?
                               `SHS_HOME_WORD16 :
                               {dec_core_sample, `SHS_LSB_PAD};
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dmode_q  <= SHS_DEC_PASS;
            ds_cnt_q <= '0;
        end else begin
            // Span restarts at the reset pulse, not at a free count
            if (dec_home)
                ds_cnt_q <= '0;
            else if (dec_core_sample_valid)
                ds_cnt_q <= ds_last ? '0 : ds_cnt_q + 8'd1;
            if (dec_home) dmode_q <= SHS_DEC_HOME_OUT;
            else if (ds_last) dmode_q <= SHS_DEC_PASS;
        end
    end

    // Registered decoder outputs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dec_out_sample <= '0;
            dec_out_valid  <= 1'b0;
            dec_core_home  <= 1'b0;
        end else begin
            dec_out_valid <= dec_core_sample_valid;
            if (dec_core_sample_valid) dec_out_sample <= dec_word;
            dec_core_home <= dec_home;
        end
    end

    // Checks
    sequence s_frame_end_home;
        frame_end && frame_home;
    endsequence
    sequence s_core_reset;
        ##1 enc_core_home;
    endsequence

    a_core_home_pulse: assert property (@(posedge ref_clk)
        disable iff (sys_rst) s_frame_end_home |-> s_core_reset)
        else $error("coder core not reset after homing frame");

    a_dhf_substitute: assert property (@(posedge ref_clk)
        disable iff (sys_rst) sub_set |=> enc_sub_q && cw_cnt_q == '0
        || enc_sub_q)
        else $error("homing substitution not armed");

    a_sub_pattern: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (cw_take && enc_sub_q) |->
        fifo_in_word == DHF_WORDS[cw_cnt_q])
        else $error("substituted word differs from homing pattern");

    a_frame_length: assert property (@(posedge ref_clk)
        disable iff (sys_rst) frame_end |-> smp_cnt_q == `SHS_LAST_SAMPLE)
        else $error("frame end not at sample 159");

    a_word_bits: assert property (@(posedge ref_clk)
        disable iff (sys_rst) word_done && !comp_mode
        |-> bit_cnt_q == `SHS_LIN_BITS - 4'd1)
        else $error("linear word not 13 bits");

    a_lin_justify: assert property (@(posedge ref_clk)
        disable iff (sys_rst) enc_core_sample_valid && !comp_mode
        |-> enc_core_sample[2:0] == 3'h0)
        else $error("linear sample low bits not zero");

    a_comp_byte: assert property (@(posedge ref_clk)
        disable iff (sys_rst) enc_core_sample_valid && comp_mode
        |-> enc_core_sample[15:8] == 8'h00)
        else $error("companded sample wider than a byte");

    a_dec_reset: assert property (@(posedge ref_clk)
        disable iff (sys_rst) dec_home |=> dec_core_home &&
        dmode_q == SHS_DEC_HOME_OUT)
        else $error("decoder not reset on homing frame");

    a_dec_home_out: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (dec_core_sample_valid &&
        dmode_q == SHS_DEC_HOME_OUT) |=> dec_out_sample == `SHS_HOME_WORD16)
        else $error("decoder homing output not 0x0008");

    a_cw_count: assert property (@(posedge ref_clk)
        disable iff (sys_rst) cw_take |-> cw_cnt_q <= `SHS_LAST_WORD)
        else $error("coded frame longer than 76 words");

    a_comp_bits: assert property (@(posedge ref_clk)
        disable iff (sys_rst) word_done && comp_mode
        |-> bit_cnt_q == `SHS_COMP_BITS - 4'd1)
        else $error("companded word not 8 bits");

    a_home_span: assert property (@(posedge ref_clk)
        disable iff (sys_rst) dec_home |=> ds_cnt_q == '0)
        else $error("homing output span not restarted");

    a_dec_pass: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (dec_core_sample_valid &&
        dmode_q == SHS_DEC_PASS) |=>
        dec_out_sample == {$past(dec_core_sample), `SHS_LSB_PAD})
        else $error("decoder sample not left justified");

    a_coded_hold: assert property (@(posedge ref_clk)
        disable iff (sys_rst) coded_valid && !coded_ready
        |=> coded_valid && $stable(coded_word))
        else $error("coded word dropped before it was taken");

    // Armed decoder sees a matching parameter block and first subframe
    sequence s_partial_match;
        dw_end && armed_q && part_hit;
    endsequence

    a_partial_home: assert property (@(posedge ref_clk)
        disable iff (sys_rst) s_partial_match |=> dec_core_home)
        else $error("partial homing frame ignored after full one");
endmodule : shs_homing_sync

// ==== verilog/shs_regs.svh ====
`ifndef SHS_REGS_SVH
`define SHS_REGS_SVH

// Frame geometry
`define SHS_FRAME_SAMPLES   8'd160
`define SHS_LAST_SAMPLE     8'd159
`define SHS_CODED_WORDS     7'd76
`define SHS_LAST_WORD       7'd75
`define SHS_PART_LAST_WORD  7'd24

// Serial word lengths, linear and companded
`define SHS_LIN_BITS        4'd13
`define SHS_COMP_BITS       4'd8

// Homing sample values
`define SHS_HOME_SAMPLE     13'h0001
`define SHS_HOME_WORD16     16'h0008
`define SHS_LSB_PAD         3'h0
`define SHS_BYTE_PAD        8'h00

// Linear bit rate and derived bit period in ref_clk cycles
`define SHS_BIT_RATE_KBPS   104
`define SHS_CLK_PERIOD_NS   20
`define SHS_BIT_CYCLES      (1000000 / (`SHS_BIT_RATE_KBPS * `SHS_CLK_PERIOD_NS))

`endif

// ==== verilog/shs_pkg.sv ====
package shs_pkg;
    typedef logic [15:0] shs_word_t;
    typedef logic [12:0] shs_sample_t;
    typedef logic [7:0]  shs_byte_t;
    typedef logic [7:0]  shs_smp_cnt_t;
    typedef logic [6:0]  shs_cw_cnt_t;
    typedef enum logic [1:0] {
        SHS_DEC_PASS,
        SHS_DEC_HOME_OUT
    } shs_dec_mode_t;
endpackage : shs_pkg

// ==== verilog/shs_fifo.sv ====
`timescale 1ns/1ps
module shs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire              empty = (wr_q == rd_q);
    wire              full  = (wr_q[AW] != rd_q[AW]) &&
                              (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire              push  = in_valid && !full;
    wire              pop   = out_valid && out_ready;

    // Honest flags; full stalls the writer
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_q[rd_q[AW-1:0]];

    // Storage, no reset needed for data
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointers with wrap bit
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
        end
    end
endmodule : shs_fifo

// ==== sim/shs_tester.sv ====
`timescale 1ns/1ps
// Tester side: drives the unmarked serial sample stream
module shs_tester (
    input  wire logic ref_clk,
    output logic      ser_clk_pin,
    output logic      ser_data_pin
);
    // Bit clock stands low between frames
    initial begin
        ser_clk_pin  = 1'b0;
        ser_data_pin = 1'b0;
    end

    // One word MSB first, three cycles low and three high per bit
    // Bit phases far shorter than nominal to keep the run short
    task automatic send_word(input logic [12:0] w, input int nbits);
        for (int b = nbits - 1; b >= 0; b--) begin
            @(posedge ref_clk) #1;
            ser_clk_pin  = 1'b0;
            ser_data_pin = w[b];
            repeat (2) @(posedge ref_clk);
            @(posedge ref_clk) #1;
            ser_clk_pin = 1'b1;
            repeat (2) @(posedge ref_clk);
        end
    endtask : send_word

    // Released line shows no stale bit
    task automatic release_line();
        @(posedge ref_clk) #1;
        ser_clk_pin  = 1'b0;
        ser_data_pin = ~ser_data_pin;
    endtask : release_line

    // 160 equal words, 13 or 8 bits each
    task automatic send_frame(input logic [12:0] w, input int nbits);
        for (int s = 0; s < 160; s++) begin
            send_word(w, nbits);
        end
        release_line();
    endtask : send_frame

    // sync frame, homing samples ahead of the offset
    task automatic send_sync(input int off, input logic [12:0] pat);
        for (int s = 0; s < 160; s++) begin
            send_word((s < off) ? 13'h0001 : pat, 13);
        end
        release_line();
    endtask : send_sync
endmodule : shs_tester

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import shs_pkg::*;
    typedef shs_word_t shs_dhf_arr_t [76];
    function automatic shs_dhf_arr_t mk_dhf();
        shs_dhf_arr_t a;
        for (int k = 0; k < 76; k++) a[k] = 16'h0200 + 16'(k);
        return a;
    endfunction : mk_dhf
    localparam shs_dhf_arr_t DHF = mk_dhf();
    // Companded homing byte; value arbitrary
    localparam logic [7:0]  HB       = 8'hd5;
    localparam int          SYNC_OFF = 37;
    localparam logic [12:0] SYNC_PAT = 13'h0abc;

    logic        ref_clk, sys_rst, ser_clk_pin, ser_data_pin;
    logic        comp_mode_pin, enc_core_sample_valid, enc_core_home;
    logic        enc_core_word_valid, enc_core_word_ready;
    logic        coded_valid, coded_ready, dec_in_valid, dec_in_bad_frame;
    logic        dec_core_home, dec_core_sample_valid, dec_out_valid;
    shs_word_t   enc_core_sample, enc_core_word, coded_word;
    shs_word_t   dec_in_word, dec_out_sample;
    shs_sample_t dec_core_sample;
    int          err_count, checks, n_smp, n_home, first_pat;
    logic        mon_on;

    shs_homing_sync #(.DHF_WORDS(DHF), .HOME_BYTE(HB)) DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst),
        .ser_clk_pin(ser_clk_pin), .ser_data_pin(ser_data_pin),
        .comp_mode_pin(comp_mode_pin),
        .enc_core_sample(enc_core_sample),
        .enc_core_sample_valid(enc_core_sample_valid),
        .enc_core_home(enc_core_home), .enc_core_word(enc_core_word),
        .enc_core_word_valid(enc_core_word_valid),
        .enc_core_word_ready(enc_core_word_ready),
        .coded_word(coded_word), .coded_valid(coded_valid),
        .coded_ready(coded_ready), .dec_in_word(dec_in_word),
        .dec_in_valid(dec_in_valid), .dec_in_bad_frame(dec_in_bad_frame),
        .dec_core_home(dec_core_home), .dec_core_sample(dec_core_sample),
        .dec_core_sample_valid(dec_core_sample_valid),
        .dec_out_sample(dec_out_sample), .dec_out_valid(dec_out_valid)
    );

    shs_tester u_tester (
        .ref_clk(ref_clk), .ser_clk_pin(ser_clk_pin),
        .ser_data_pin(ser_data_pin)
    );

    // Free running 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input shs_word_t exp,
                         input shs_word_t got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    // expected sample: sync pattern from its offset on
    function automatic shs_word_t exp_smp(input int n);
        if (comp_mode_pin) return {8'h00, HB};
        if (n > 480 && n - 481 >= SYNC_OFF) return {SYNC_PAT, 3'h0};
        return 16'h0008;
    endfunction : exp_smp

    // Encoder sample monitor, mid-cycle where outputs are settled
    always @(negedge ref_clk) begin
        if (mon_on && enc_core_sample_valid === 1'b1) begin
            n_smp++;
            check("enc sample", exp_smp(n_smp), enc_core_sample);
            if (n_smp > 480 && first_pat < 0 &&
                enc_core_sample === {SYNC_PAT, 3'h0})
                first_pat = n_smp - 481;
        end
        if (mon_on && enc_core_home === 1'b1) n_home++;
    end

    // Core side pushes 76 words; the sink stalls until the FIFO holds 32, then drains at half rate
    task automatic run_words(input logic use_dhf);
        int i, j, cyc;
        logic full;
        i = 0;
        j = 0;
        full = 1'b0;
        for (cyc = 0; cyc < 1000 && j < 76; cyc++) begin
            @(posedge ref_clk) #1;
            enc_core_word_valid = (i < 76);
            enc_core_word = 16'h0100 + 16'(i);
            coded_ready = full & cyc[0];
            #15;
            if (!full && enc_core_word_ready === 1'b0) begin
                full = 1'b1;
                check("fifo fill", 16'd32, 16'(i));
            end
            if (enc_core_word_valid && enc_core_word_ready === 1'b1) i++;
            if (coded_valid === 1'b1 && coded_ready) begin
                check("coded word",
                      use_dhf ? DHF[j] : 16'h0100 + 16'(j), coded_word);
                j++;
            end
        end
        check("coded count", 16'd76, 16'(j));
        @(posedge ref_clk) #1;
        coded_ready = 1'b0;
        check("fifo empty", 16'h0000, {15'h0, coded_valid});
    endtask : run_words

    // Three homing frames, then the sync frame at a known offset
    task automatic serial_homing();
        n_smp = 0;
        n_home = 0;
        first_pat = -1;
        mon_on = 1'b1;
        repeat (3) u_tester.send_frame(13'h0001, 13);
        u_tester.send_sync(SYNC_OFF, SYNC_PAT);
        repeat (8) @(posedge ref_clk);
        mon_on = 1'b0;
        check("sample count", 16'd640, 16'(n_smp));
        check("home pulses", 16'd3, 16'(n_home));
        // Recorded offset is the shift the tester applied
        check("sync offset", 16'(SYNC_OFF), 16'(first_pat));
    endtask : serial_homing

    // One companded homing frame of one-byte samples
    task automatic comp_homing();
        @(posedge ref_clk) #1;
        comp_mode_pin = 1'b1;
        repeat (4) @(posedge ref_clk);
        n_smp = 0;
        n_home = 0;
        first_pat = -1;
        mon_on = 1'b1;
        u_tester.send_frame({5'h00, HB}, 8);
        repeat (8) @(posedge ref_clk);
        mon_on = 1'b0;
        check("comp sample count", 16'd160, 16'(n_smp));
        check("comp home pulses", 16'd1, 16'(n_home));
        #1 comp_mode_pin = 1'b0;
    endtask : comp_homing

    // One coded frame into the decoder, first nfull words homing
    task automatic dec_frame(input int nfull, input logic bad,
                             input logic exp, input logic chk);
        for (int k = 0; k < 76; k++) begin
            @(posedge ref_clk) #1;
            dec_in_valid = 1'b1;
            dec_in_word = (k < nfull) ? DHF[k] : 16'h7fff;
            dec_in_bad_frame = (k == 75) ? bad : 1'b0;
        end
        @(posedge ref_clk) #1;
        dec_in_valid = 1'b0;
        dec_in_bad_frame = 1'b0;
        if (chk) check("dec home", {15'h0, exp}, {15'h0, dec_core_home});
    endtask : dec_frame

    // Core samples in, judged one cycle later
    task automatic dec_smp(input int n, input shs_word_t exp);
        for (int k = 0; k <= n; k++) begin
            @(posedge ref_clk) #1;
            if (k > 0) check("dec out", exp, dec_out_sample);
            if (k > 0) check("dec out valid", 16'h0001, {15'h0, dec_out_valid});
            dec_core_sample_valid = (k < n);
            dec_core_sample = 13'h0abc;
        end
    endtask : dec_smp

    // Hang guard, about half again the expected run
    initial begin
        repeat (90000) @(posedge ref_clk);
        err_count++;
        $display("[ERR] run length expected done seen timeout");
        finish_test();
    end

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        {comp_mode_pin, enc_core_word_valid, coded_ready} = '0;
        {dec_in_valid, dec_in_bad_frame, dec_core_sample_valid} = '0;
        {enc_core_word, dec_in_word, dec_core_sample} = '0;
        {err_count, checks, n_smp, n_home} = '0;
        mon_on = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        check("ready at reset", 16'h0001, {15'h0, enc_core_word_ready});
        run_words(1'b0);
        serial_homing();
        run_words(1'b1);
        comp_homing();
        dec_frame(76, 1'b0, 1'b1, 1'b1);
        dec_smp(160, 16'h0008);
        dec_smp(1, 16'h55e0);
        dec_frame(76, 1'b0, 1'b1, 1'b1);
        dec_frame(25, 1'b0, 1'b1, 1'b1);
        dec_smp(160, 16'h0008);
        dec_smp(1, 16'h55e0);
        dec_frame(25, 1'b0, 1'b0, 1'b1);
        dec_frame(76, 1'b1, 1'b0, 1'b0);
        dec_frame(25, 1'b0, 1'b0, 1'b1);
        finish_test();
    end
endmodule : testbench
